// ===== sim/dcf_fifo_assertions.sv
`timescale 1ns/1ps
module dcf_fifo_assertions (
  input wire        sys_clk,
  input wire        rstn,
  input wire        ren_n,
  input wire        timing_select_serial_in,
  input wire [17:0] data_out,
  input wire        empty_flag_n,
  input wire        full_flag_n,
  input wire        almost_empty_n,
  input wire        almost_full_n,
  input wire        half_level_n
);
  reg m_q;

  // mode strap as seen during reset
  always @(posedge sys_clk) begin
    if (!rstn) m_q <= timing_select_serial_in;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_rst;
    $rose(rstn) |-> data_out == 0 && !empty_flag_n && full_flag_n
      && !almost_empty_n && almost_full_n && half_level_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_excl;
    !m_q |-> empty_flag_n || full_flag_n;
  endproperty
  a_excl: assert property (p_excl) else $error("empty and full");
  property p_full_af;
    !m_q && !full_flag_n |-> !almost_full_n;
  endproperty
  a_full_af: assert property (p_full_af) else $error("full not almost");
  property p_full_hf;
    !m_q && !full_flag_n |-> !half_level_n;
  endproperty
  a_full_hf: assert property (p_full_hf) else $error("full not half");
  property p_emp_ae;
    !m_q && !empty_flag_n |-> !almost_empty_n;
  endproperty
  a_emp_ae: assert property (p_emp_ae) else $error("empty not almost");
  property p_idle;
    !m_q && !empty_flag_n && $past(empty_flag_n, 8) == 0 |=> $stable(data_out);
  endproperty
  a_idle: assert property (p_idle) else $error("read while empty");
  property p_rd;
    !m_q && $changed(data_out) |-> $past(ren_n, 3) == 0;
  endproperty
  a_rd: assert property (p_rd) else $error("data without request");
  property p_or;
    m_q && $rose(rstn) |-> ##[1:3] empty_flag_n;
  endproperty
  a_or: assert property (p_or) else $error("ready flag late");
  property p_ir;
    m_q && $rose(rstn) |-> ##[0:2] !full_flag_n;
  endproperty
  a_ir: assert property (p_ir) else $error("input ready late");
endmodule

// ===== sim/dcf_fifo_bench.sv
`timescale 1ns/1ps
module dcf_fifo_bench;
  localparam D = 256;
  localparam N = 127;
  localparam M = 127;
  reg         sys_clk, rstn, mode, lds;
  wire        wclk, rclk, wen_n, ren_n, ef, ff, ae, af, hf;
  wire [17:0] din, dout;
  integer     n_fail, check_count, cyc, i;

  dcf_fifo #(.ADDR_W(8)) dcf_fifo_inst (.sys_clk(sys_clk), .rstn(rstn),
    .wclk(wclk), .rclk(rclk), .wen_n(wen_n), .ren_n(ren_n), .data_in(din),
    .timing_select_serial_in(mode), .load_select_n(lds), .data_out(dout),
    .empty_flag_n(ef), .full_flag_n(ff), .almost_empty_n(ae),
    .almost_full_n(af), .half_level_n(hf));
  dcf_link_model dcf_link_model_inst (.sys_clk(sys_clk), .wclk(wclk),
    .rclk(rclk), .wen_n(wen_n), .ren_n(ren_n), .data_in(din));

  // block clock
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task close_out;
    begin
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // flags expected for a stored count
  task flags(input integer c);
    begin
      repeat (100) @(posedge sys_clk);
      chk({ef, ff, ae, af, hf}, {c != 0, c != D, c > N, c < D - M, c <= D / 2});
    end
  endtask

  task do_reset(input m);
    begin
      rstn <= 1'h0;
      mode <= m;
      repeat (4) @(posedge sys_clk);
      rstn <= 1'h1;
      @(posedge sys_clk);
    end
  endtask

  task t_fall_through_mode;
    begin
      do_reset(1'h1);
      repeat (20) @(posedge sys_clk);
      chk({ef, ff}, 2'h2);
      // the first read edge after the write passes before wr returns
      dcf_link_model_inst.wr(18'h15A5A);
      @(posedge rclk);
      repeat (10) @(posedge sys_clk);
      chk({dout, ef}, {18'h00000, 1'h1});
      @(posedge rclk);
      repeat (10) @(posedge sys_clk);
      chk({dout, ef}, {18'h15A5A, 1'h0});
      dcf_link_model_inst.rd;
      repeat (100) @(posedge sys_clk);
      chk(ef, 1'h1);
    end
  endtask

  task t_std;
    begin
      do_reset(1'h0);
      flags(0);
      for (i = 1; i <= D; i = i + 1) begin
        dcf_link_model_inst.wr(i);
        if (i == 1 || i == N || i == N + 1 || i == D - M || i == D - 1 || i == D)
          flags(i);
      end
      dcf_link_model_inst.wr(18'h3FFFF);
      flags(D);
      for (i = 1; i <= D; i = i + 1) begin
        dcf_link_model_inst.rd;
        chk(dout, i);
        if (i == 1 || i == D - N - 1 || i == D - N || i == D)
          flags(D - i);
      end
      dcf_link_model_inst.rd;
      chk(dout, D);
      flags(0);
    end
  endtask

  // hang guard
  initial begin
    cyc = 0;
    forever begin
      @(posedge sys_clk);
      cyc = cyc + 1;
      if (cyc == 60000) begin
        n_fail = n_fail + 1;
        close_out;
      end
    end
  end

  // main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    rstn = 0;
    mode = 0;
    lds = 0;
    t_fall_through_mode;
    t_std;
    close_out;
  end
endmodule

bind dcf_fifo dcf_fifo_assertions dcf_fifo_assertions_inst (.sys_clk(sys_clk),
  .rstn(rstn), .ren_n(ren_n), .timing_select_serial_in(timing_select_serial_in),
  .data_out(data_out), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
  .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
  .half_level_n(half_level_n));

// ===== sim/dcf_link_model.sv
`timescale 1ns/1ps
module dcf_link_model (
  input  wire        sys_clk,
  output reg         wclk,
  output reg         rclk,
  output reg         wen_n,
  output reg         ren_n,
  output reg  [17:0] data_in
);
  // free link clocks, unrelated phase
  initial begin
    wclk = 0;
    #1; // keep link edges off the sys_clk edges
    forever #62.5 wclk = ~wclk;
  end
  initial begin
    rclk = 0;
    #37;
    forever #62.5 rclk = ~rclk;
  end
  initial begin
    wen_n = 1;
    ren_n = 1;
    data_in = 18'h3FFFF;
  end

  task wr(input [17:0] d);
    begin
      @(negedge wclk);
      @(posedge sys_clk);
      wen_n <= 1'h0;
      data_in <= d;
      @(negedge wclk);
      @(posedge sys_clk);
      wen_n <= 1'h1;
      data_in <= ~d; // stale data inverted
    end
  endtask

  task rd;
    begin
      @(negedge rclk);
      @(posedge sys_clk);
      ren_n <= 1'h0;
      @(negedge rclk);
      @(posedge sys_clk);
      ren_n <= 1'h1;
    end
  endtask
endmodule

// ===== verilog/dcf_fifo.v
`timescale 1ns/1ps
`include "dcf_fifo_regs.vh"

module dcf_fifo #(
  parameter ADDR_W = `DCF_ADDR_W_DEF
) (
  input  wire                   sys_clk,
  input  wire                   rstn,
  input  wire                   wclk,
  input  wire                   rclk,
  input  wire                   wen_n,
  input  wire                   ren_n,
  input  wire [`DCF_DATA_W-1:0] data_in,
  input  wire                   timing_select_serial_in,
  input  wire                   load_select_n,
  output reg  [`DCF_DATA_W-1:0] data_out,
  output reg                    empty_flag_n,
  output reg                    full_flag_n,
  output reg                    almost_empty_n,
  output reg                    almost_full_n,
  output reg                    half_level_n
);

  // pointer width keeps one wrap bit above the address, so full and
  // empty differ by that bit alone; count width also holds depth plus
  // the extra word that the fall-through output register can carry
  localparam PW    = ADDR_W + 1;
  localparam CW    = ADDR_W + 2;
  localparam DEPTH = 1 << ADDR_W;

  // depth, half depth and unit step at count width; unit step at pointer width
  localparam [CW-1:0] DEP  = {2'h1, {ADDR_W{1'b0}}};
  localparam [CW-1:0] HALF = {3'h1, {(ADDR_W-1){1'b0}}};
  localparam [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};
  localparam [PW-1:0] PONE = {{(PW-1){1'b0}}, 1'b1};

  // gray encode
  // one bit moves per step, so a pointer caught mid-change reads
  // as either the old or the new value, never a stray third one
  function [PW-1:0] b2g;
    input [PW-1:0] b;
    begin
      b2g = b ^ (b >> 1);
    end
  endfunction

  // gray decode
  function [PW-1:0] g2b;
    input [PW-1:0] g;
    integer        i;
    begin
      g2b[PW-1] = g[PW-1];
      for (i = PW - 2; i >= 0; i = i - 1) begin
        g2b[i] = g2b[i+1] ^ g[i];
      end
    end
  endfunction

  // pin synchronisers; first stages feed only second stages
  // every pin is foreign to sys_clk; data and enables ride the same
  // two stages as the link clocks, so they line up with the edge found
  // a third stage on each link clock only serves the edge detector
  reg                   wclk_s1_q, wclk_s2_q, wclk_s3_q;
  reg                   rclk_s1_q, rclk_s2_q, rclk_s3_q;
  reg                   wen_s1_q,  wen_s2_q;
  reg                   ren_s1_q,  ren_s2_q;
  reg                   tsel_s1_q, tsel_s2_q;
  reg                   ld_s1_q,   ld_s2_q;
  reg [`DCF_DATA_W-1:0] din_s1_q,  din_s2_q;

  always @(posedge sys_clk) begin
    wclk_s1_q <= wclk;
    wclk_s2_q <= wclk_s1_q;
    wclk_s3_q <= wclk_s2_q;
    rclk_s1_q <= rclk;
    rclk_s2_q <= rclk_s1_q;
    rclk_s3_q <= rclk_s2_q;
    wen_s1_q  <= wen_n;
    wen_s2_q  <= wen_s1_q;
    ren_s1_q  <= ren_n;
    ren_s2_q  <= ren_s1_q;
    tsel_s1_q <= timing_select_serial_in;
    tsel_s2_q <= tsel_s1_q;
    ld_s1_q   <= load_select_n;
    ld_s2_q   <= ld_s1_q;
    din_s1_q  <= data_in;
    din_s2_q  <= din_s1_q;
  end

  // rising edges of the link clocks
  // limitation: each link clock must stay high and low for at least two
  // sys_clk periods, or an edge slips past the detector unseen
  wire wr_edge = wclk_s2_q & ~wclk_s3_q;
  wire rd_edge = rclk_s2_q & ~rclk_s3_q;

  // configuration caught while reset is held
  // the straps are sampled on every reset cycle, so the level seen two
  // cycles before release wins; reset must outlast the strap stages
  reg          fall_through_mode_q;
  reg [CW-1:0] off_e_q;
  reg [CW-1:0] off_f_q;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      fall_through_mode_q  <= (tsel_s2_q == `DCF_MODE_FALL_THROUGH_MODE);
      off_e_q <= {{(CW-`DCF_OFF_W){1'b0}},
                  (ld_s2_q == `DCF_LD_SERIAL) ? `DCF_OFF_SERIAL : `DCF_OFF_PARALLEL};
      off_f_q <= {{(CW-`DCF_OFF_W){1'b0}},
                  (ld_s2_q == `DCF_LD_SERIAL) ? `DCF_OFF_SERIAL : `DCF_OFF_PARALLEL};
    end
  end

  // storage
  // the two-entry skid buffer catches words while memory is stalled,
  // so a late flag on the write side never loses a word already taken
  reg [`DCF_DATA_W-1:0] mem [0:DEPTH-1];
  reg [`DCF_DATA_W-1:0] buf_q [0:1];
  reg                   bwsel_q, brsel_q;
  reg [1:0]             bcnt_q;

  // pointers: memory write, memory read, and words handed to the reader
  // the write side frees space on the handed-over count, not on the
  // memory read, so a word parked in the output register still counts
  reg [PW-1:0] wptr_q, rptr_q, cptr_q;
  reg [PW-1:0] wg_q, cg_q;
  reg [PW-1:0] wg_r1_q, wg_r2_q;
  reg [PW-1:0] cg_w1_q, cg_w2_q;
  reg          ov_q;

  // write-side view of stored words, skid buffer included
  // the reader's count arrives two write edges late, so full and the
  // write-side flags may linger after a read; they never clear early
  wire [PW-1:0] c_view = g2b(cg_w2_q);
  wire [PW-1:0] w_diff = wptr_q - c_view;
  wire [CW-1:0] wtot   = {1'b0, w_diff} + {{(CW-2){1'b0}}, bcnt_q};
  // fall-through holds one more word in the output register
  wire [CW-1:0] cap    = fall_through_mode_q ? DEP + ONE : DEP;
  wire          full_i = (wtot >= cap);

  // a write refused while full is lost; the writer must watch the flag
  // capture on a write edge with enable low
  wire push  = wr_edge & ~wen_s2_q & ~full_i & (bcnt_q != `DCF_BUF_FULL);
  // memory stalls drain when it holds a whole depth
  // in fall-through the last word may then wait here until a read
  wire drain = (bcnt_q != `DCF_BUF_EMPTY) & ({1'b0, w_diff} < DEP);

  // read-side view
  // the write pointer arrives two read edges late, so empty may hold a
  // little longer than the store, never release before the word lands
  wire [PW-1:0] w_view  = g2b(wg_r2_q);
  wire [PW-1:0] r_mem   = w_view - rptr_q;
  wire          empty_i = (r_mem == {PW{1'b0}});
  // one request per word in standard mode
  wire take_std = ~fall_through_mode_q & rd_edge & ~ren_s2_q & ~empty_i;
  // later fall-through words need read enable
  wire take_ft  = fall_through_mode_q & rd_edge & ~ren_s2_q & ov_q;
  // first word: two read edges carry the pointer over, the third
  // fetches it into the output register
  // fetch on the edge after two sync edges, no enable
  wire fetch    = fall_through_mode_q & rd_edge & ~empty_i & (~ov_q | take_ft);
  wire [PW-1:0] rc_ft = w_view - cptr_q;
  // stored count: words not yet handed to the reader, which in
  // fall-through already includes the word in the output register
  wire [CW-1:0] rcnt  = fall_through_mode_q ? {1'b0, rc_ft} : {1'b0, r_mem};

  // skid buffer and memory write side
  // push and drain may fall in one cycle; the count then stays put
  always @(posedge sys_clk) begin
    if (!rstn) begin
      bwsel_q <= 1'h0;
      brsel_q <= 1'h0;
      bcnt_q  <= `DCF_BUF_EMPTY;
      wptr_q  <= {PW{1'b0}};
      wg_q    <= {PW{1'b0}};
    end else begin
      if (push) begin
        buf_q[bwsel_q] <= din_s2_q;
        bwsel_q        <= ~bwsel_q;
      end
      if (drain) begin
        mem[wptr_q[ADDR_W-1:0]] <= buf_q[brsel_q];
        brsel_q                 <= ~brsel_q;
        wptr_q                  <= wptr_q + PONE;
        wg_q                    <= b2g(wptr_q + PONE);
      end
      bcnt_q <= bcnt_q + {1'b0, push} - {1'b0, drain};
    end
  end

  // gray pointers sampled twice on the far side's edges
  // stages advance only on far-side edges, so a stopped link clock
  // freezes the view of the other side and its flags with it
  always @(posedge sys_clk) begin
    if (!rstn) begin
      wg_r1_q <= {PW{1'b0}};
      wg_r2_q <= {PW{1'b0}};
      cg_w1_q <= {PW{1'b0}};
      cg_w2_q <= {PW{1'b0}};
    end else begin
      if (rd_edge) begin
        wg_r1_q <= wg_q;
        wg_r2_q <= wg_r1_q;
      end
      if (wr_edge) begin
        cg_w1_q <= cg_q;
        cg_w2_q <= cg_w1_q;
      end
    end
  end

  // read side: standard pops, fall-through output register
  // in fall-through a fetch and a take may share a cycle: the output
  // register then refills at once and stays valid
  always @(posedge sys_clk) begin
    if (!rstn) begin
      rptr_q   <= {PW{1'b0}};
      cptr_q   <= {PW{1'b0}};
      cg_q     <= {PW{1'b0}};
      ov_q     <= 1'h0;
      data_out <= {`DCF_DATA_W{1'b0}};
    end else begin
      if (take_std | fetch) begin
        data_out <= mem[rptr_q[ADDR_W-1:0]];
        rptr_q   <= rptr_q + PONE;
      end
      // a taken word frees space for the writer
      if (take_std | take_ft) begin
        cptr_q <= cptr_q + PONE;
        cg_q   <= b2g(cptr_q + PONE);
      end
      if (fetch) begin
        ov_q <= 1'h1;
      end else if (take_ft) begin
        ov_q <= 1'h0;
      end
    end
  end

  // flag stages
  // the same pins carry ready flags in fall-through; the empty stage count
  // follows the mode, so empty and output-ready latency differ by one stage
  reg ef_s1_q, ef_s2_q;
  reg ff_s1_q;

  always @(posedge sys_clk) begin
    if (!rstn) begin
      ef_s1_q        <= `DCF_EF_RST;
      ef_s2_q        <= `DCF_EF_RST;
      ff_s1_q        <= `DCF_FF_RST;
      empty_flag_n   <= `DCF_EF_RST;
      full_flag_n    <= `DCF_FF_RST;
      almost_empty_n <= `DCF_AE_RST;
      almost_full_n  <= `DCF_AF_RST;
      half_level_n   <= `DCF_HF_RST;
    end else begin
      // empty flag high once a word is stored; in fall-through, output-ready low once the output register holds one
      // two stages for empty in standard mode
      ef_s1_q      <= fall_through_mode_q ? ~ov_q : ~empty_i;
      ef_s2_q      <= ef_s1_q;
      empty_flag_n <= fall_through_mode_q ? ef_s2_q : ef_s1_q;
      // full low at depth, input-ready high at depth plus one
      // two stages for full and input-ready
      ff_s1_q      <= fall_through_mode_q ? full_i : ~full_i;
      full_flag_n  <= ff_s1_q;
      // almost-empty high at offset plus one, plus two in fall-through
      // almost-empty low at offset and below, offset plus one in fall-through
      almost_empty_n <= (rcnt > off_e_q + {{(CW-1){1'b0}}, fall_through_mode_q});
      // almost-full low at depth minus offset
      // cap already holds the extra fall-through word, so one compare
      // serves both modes
      almost_full_n  <= ~(wtot >= cap - off_f_q);
      // fall-through threshold moves up by the output word
      // half flag low past half depth
      half_level_n   <= ~(wtot > HALF + {{(CW-1){1'b0}}, fall_through_mode_q});
    end
  end

endmodule

// ===== verilog/dcf_fifo_regs.vh
`ifndef DCF_FIFO_REGS_VH
`define DCF_FIFO_REGS_VH

// data path width
`define DCF_DATA_W        18
// address width; 13 gives 8,192 words, 14 gives 16,384 words
`define DCF_ADDR_W_DEF    13

// offset register width and the two preset offsets
`define DCF_OFF_W         10
`define DCF_OFF_SERIAL    10'h3FF
`define DCF_OFF_PARALLEL  10'h07F

// timing select level that picks fall-through
`define DCF_MODE_FALL_THROUGH_MODE     1'h1
// load select level that picks the serial presets
`define DCF_LD_SERIAL     1'h1

// flag levels driven while reset is held
`define DCF_EF_RST        1'h0
`define DCF_FF_RST        1'h1
`define DCF_AE_RST        1'h0
`define DCF_AF_RST        1'h1
`define DCF_HF_RST        1'h1

// two-entry input skid buffer
`define DCF_BUF_FULL      2'h2
`define DCF_BUF_EMPTY     2'h0

`endif
